// ### hw/sar_pkg.sv
/*
  Shared constants for the converter control block: register map, field
  positions, reset values, multiplexer codes and output word layout.
  Assumes a 4-bit byte address on the register port, word aligned.
*/
package sar_pkg;

  // Register byte addresses
  localparam logic [3:0] ADDR_CTRL   = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam logic [3:0] ADDR_RESULT = 4'h8;
  localparam logic [3:0] ADDR_LATCH  = 4'hC;

  // Control register fields
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_SHORT_BIT  = 1;
  localparam logic [1:0] CTRL_RESET = 2'h1;

  // Status register fields
  localparam int STAT_BUSY_BIT  = 0;
  localparam int STAT_AVAIL_BIT = 1;
  localparam int STAT_FULL_BIT  = 2;
  localparam int STAT_PAIR_MODE_SEL_BIT  = 3;

  // Resolutions and word layout
  localparam int FULL_BITS  = 12;
  localparam int SHORT_BITS = 10;
  localparam int ADDR_BITS  = 4;
  localparam int WORD_BITS  = 16;
  localparam int FIFO_DEPTH = 8;

  // Multiplexer select codes: 0..7 analog inputs, 8 common input
  localparam logic [3:0] SEL_COMMON = 4'h8;

  // Input span codes, {polarity_select, gain_select}
  typedef enum logic [1:0] {
    SPAN_UNI_HALF = 2'h0,
    SPAN_UNI_FULL = 2'h1,
    SPAN_BIP_QTR  = 2'h2,
    SPAN_BIP_HALF = 2'h3
  } span_e;

endpackage

// ### hw/fifo_if.sv
/*
  Valid/ready carrier between the converter control and its result FIFO.
  Pop side: out_ready requests a word, data appear one cycle later.
*/
`timescale 1ns/100ps
interface fifo_if #(parameter int W = 16);
  logic         in_valid;
  logic         in_ready;
  logic [W-1:0] in_data;
  logic         out_valid;
  logic         out_ready;
  logic [W-1:0] out_data;

  modport fifo (input in_valid, in_data, out_ready,
                output in_ready, out_valid, out_data);
  modport user (output in_valid, in_data, out_ready,
                input in_ready, out_valid, out_data);
endinterface

// ### hw/sample_fifo.sv
/*
  Result FIFO with parameter width and depth; read data leave a register.
  Assumes a single clock and a consumer that pops only while out_valid.
*/
`timescale 1ns/100ps
module sample_fifo #(
  parameter int W     = 16,
  parameter int DEPTH = 8
) (
  input  wire logic mclk_in,   // System clock
  input  wire logic reset_in,  // Async reset, active high
  fifo_if.fifo      port       // Push and pop sides
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0]  mem [DEPTH];
  logic [AW-1:0] wptr_r;
  logic [AW-1:0] rptr_r;
  logic [AW:0]   count_r;
  logic [W-1:0]  dout_r;
  wire           push = port.in_valid && port.in_ready;
  wire           pop  = port.out_ready && port.out_valid;

  assign port.in_ready  = (count_r != (AW+1)'(DEPTH));
  assign port.out_valid = (count_r != '0);
  assign port.out_data  = dout_r;

  always_ff @(posedge mclk_in)
  begin
    if (push)
      mem[wptr_r] <= port.in_data;
  end

  always_ff @(posedge mclk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      wptr_r  <= '0;
      rptr_r  <= '0;
      count_r <= '0;
      dout_r  <= '0;
    end
    else
    begin
      if (push)
        wptr_r <= (wptr_r == AW'(DEPTH-1)) ? '0 : wptr_r + 1'b1;
      if (pop)
      begin
        dout_r <= mem[rptr_r];
        rptr_r <= (rptr_r == AW'(DEPTH-1)) ? '0 : rptr_r + 1'b1;
      end
      count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule // sample_fifo

// ### hw/sar_conversion_and_mux_select.sv
/*
  Control logic of an eight-channel successive-approximation converter:
  start detection, bit decisions, output latch, multiplexer and span
  decode, result FIFO and a small register port.
  Assumes pins synchronous to mclk_in and a comparator that settles
  within one clock of a new trial code.
*/
// The implementer's own choices: the strobed register port and the register offsets.
// Overview of operation
// - A conversion starts only from the device select and convert request pins.
// - The bit decision register is cleared as each conversion begins.
// - Start requests during a conversion are ignored; it cannot be restarted.
// - Bits are decided one at a time from MSB to LSB over 10 or 12 bits.
// - At the end the result and the 4-bit channel address load a 14/16-bit latch.
// - The result is the difference of the positive and negative mux outputs.
// - Pair mode low gives eight single-ended inputs, high gives four pairs.
// - Single-ended, the address picks the positive input; common is negative.
// - Differential, the upper bits pick the pair and bit 0 the positive side.
// - Gain select high gives gain 1, low gives gain 2 with half the span.
// - Polarity select low is unipolar, high bipolar, four spans in all.
`timescale 1ns/100ps
module sar_conversion_and_mux_select #(
  parameter int RES_BITS = sar_pkg::FULL_BITS,
  parameter int FIFO_D   = sar_pkg::FIFO_DEPTH
) (
  input  wire logic        mclk_in,              // 10 MHz clock
  input  wire logic        reset_in,             // Async reset, high
  input  wire logic        cs_n_in,              // Device select, low
  input  wire logic        convert_request_n_in, // Start, falling edge
  input  wire logic        pair_mode_sel_in,     // High: differential
  input  wire logic        channel_addr_bit2_in, // Mux address bit 2
  input  wire logic        channel_addr_bit1_in, // Mux address bit 1
  input  wire logic        channel_addr_bit0_in, // Mux address bit 0
  input  wire logic        gain_select_in,       // High: gain 1
  input  wire logic        polarity_select_in,   // High: bipolar
  input  wire logic        comparator_in,        // High: input >= trial
  output logic [RES_BITS-1:0] trial_code_out,    // DAC trial code
  output logic             sample_out,           // Acquire phase
  output logic [3:0]       pos_sel_out,          // Positive mux select
  output logic [3:0]       neg_sel_out,          // Negative mux select
  output sar_pkg::span_e   span_sel_out,         // Input span
  output logic             busy_out,             // Conversion running
  output logic [sar_pkg::WORD_BITS-1:0] data_out,// Parallel output latch
  input  wire logic [3:0]  addr_in,              // Register address
  input  wire logic [31:0] wdata_in,             // Register write data
  input  wire logic        wr_in,                // Write strobe
  input  wire logic        rd_in,                // Read strobe
  output logic [31:0]      rdata_out             // Read data, next cycle
);
  import sar_pkg::*;

  localparam int IDX_W = $clog2(RES_BITS);

  typedef enum {ST_IDLE, ST_CONVERT, ST_LOAD} conv_state_e;

  conv_state_e         state_r;
  conv_state_e         state_nxt;
  logic [RES_BITS-1:0] bdr_r;            // Bit decision register
  logic [RES_BITS-1:0] bdr_nxt;
  logic [IDX_W-1:0]    idx_r;
  logic [IDX_W-1:0]    idx_nxt;
  logic                req_n_r;
  logic [1:0]          ctrl_r;
  logic                cfg_pair_mode_sel_r;
  logic [2:0]          cfg_addr_r;
  logic                cfg_gain_r;
  logic                cfg_pol_r;
  logic                cfg_short_r;
  logic [WORD_BITS-1:0] latch_r;
  logic [3:0]          rd_sel_r;
  logic                rd_empty_r;
  logic [31:0]         rd_hold_r;

  fifo_if #(.W(WORD_BITS)) res_q ();

  sample_fifo #(
    .W     (WORD_BITS),
    .DEPTH (FIFO_D)
  ) u_fifo (
    .mclk_in  (mclk_in),
    .reset_in (reset_in),
    .port     (res_q)
  );

  // Start detection and conversion sequencing
  wire req_fall  = req_n_r && !convert_request_n_in;
  wire start_req = !cs_n_in && req_fall;
  wire start_ok  = start_req && ctrl_r[CTRL_ENABLE_BIT]
                   && (state_r == ST_IDLE);
  // Short mode keeps full-scale trial weights and stops two bits early
  wire [IDX_W-1:0] top_idx = IDX_W'(RES_BITS - 1);
  wire [IDX_W-1:0] low_idx = cfg_short_r
                   ? IDX_W'(FULL_BITS - SHORT_BITS) : '0;
  wire [RES_BITS-1:0] bit_mask = RES_BITS'(1) << idx_r;
  wire [RES_BITS-1:0] trial    = bdr_r | bit_mask;
  wire last_bit  = (idx_r == low_idx);
  wire load_go   = (state_r == ST_LOAD) && res_q.in_ready;

  // Comparator sees the charge of positive minus negative input
  wire [RES_BITS-1:0] decided = comparator_in ? trial : bdr_r;

  always_comb
  begin
    state_nxt = state_r;
    bdr_nxt   = bdr_r;
    idx_nxt   = idx_r;
    case (state_r)
      ST_IDLE:
        if (start_ok)
        begin
          state_nxt = ST_CONVERT;
          bdr_nxt   = '0;
          idx_nxt   = top_idx;
        end
      ST_CONVERT:
      begin
        bdr_nxt = decided;
        if (last_bit)
          state_nxt = ST_LOAD;
        else
          idx_nxt = idx_r - 1'b1;
      end
      ST_LOAD:
        if (res_q.in_ready)
          state_nxt = ST_IDLE;
      default:
        state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      state_r <= ST_IDLE;
      bdr_r   <= '0;
      idx_r   <= '0;
      req_n_r <= 1'b1;
    end
    else
    begin
      state_r <= state_nxt;
      bdr_r   <= bdr_nxt;
      idx_r   <= idx_nxt;
      req_n_r <= convert_request_n_in;
    end
  end

  // Configuration held for the whole conversion
  always_ff @(posedge mclk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      cfg_pair_mode_sel_r  <= 1'b0;
      cfg_addr_r  <= '0;
      cfg_gain_r  <= 1'b0;
      cfg_pol_r   <= 1'b0;
      cfg_short_r <= 1'b0;
    end
    else if (start_ok)
    begin
      cfg_pair_mode_sel_r  <= pair_mode_sel_in;
      cfg_addr_r  <= {channel_addr_bit2_in, channel_addr_bit1_in,
                      channel_addr_bit0_in};
      cfg_gain_r  <= gain_select_in;
      cfg_pol_r   <= polarity_select_in;
      cfg_short_r <= ctrl_r[CTRL_SHORT_BIT];
    end
  end

  // Multiplexer and span decode
  wire [3:0] se_pos   = {1'b0, cfg_addr_r};
  wire [3:0] pair_pos = {1'b0, cfg_addr_r};
  wire [3:0] pair_neg = {1'b0, cfg_addr_r[2:1], ~cfg_addr_r[0]};
  assign pos_sel_out  = cfg_pair_mode_sel_r ? pair_pos : se_pos;
  assign neg_sel_out  = cfg_pair_mode_sel_r ? pair_neg : SEL_COMMON;
  assign span_sel_out = span_e'({cfg_pol_r, cfg_gain_r});

  // Output word: zero pad, channel address, result
  wire [ADDR_BITS-1:0] addr_word = {cfg_pair_mode_sel_r, cfg_addr_r};
  wire [WORD_BITS-1:0] word_full =
    WORD_BITS'({addr_word, bdr_r});
  wire [WORD_BITS-1:0] word_short =
    WORD_BITS'({addr_word, bdr_r[RES_BITS-1 -: SHORT_BITS]});
  wire [WORD_BITS-1:0] result_word = cfg_short_r ? word_short : word_full;

  // A full FIFO stalls in ST_LOAD so latch and FIFO never disagree
  always_ff @(posedge mclk_in or posedge reset_in)
  begin
    if (reset_in)
      latch_r <= '0;
    else if (load_go)
      latch_r <= result_word;
  end

  assign res_q.in_valid = (state_r == ST_LOAD);
  assign res_q.in_data  = result_word;
  assign trial_code_out = (state_r == ST_CONVERT) ? trial : '0;
  assign sample_out     = (state_r == ST_IDLE);
  assign busy_out       = (state_r != ST_IDLE);
  assign data_out       = latch_r;

  // Register port
  wire wr_ctrl   = wr_in && (addr_in == ADDR_CTRL);
  wire rd_result = rd_in && (addr_in == ADDR_RESULT);
  assign res_q.out_ready = rd_result;

  wire [31:0] status_word = 32'({cfg_pair_mode_sel_r, !res_q.in_ready,
                                 res_q.out_valid, busy_out});
  wire [31:0] rd_mux =
    (addr_in == ADDR_CTRL)   ? 32'(ctrl_r) :
    (addr_in == ADDR_STATUS) ? status_word :
    (addr_in == ADDR_LATCH)  ? 32'(latch_r) : '0;

  always_ff @(posedge mclk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      ctrl_r     <= CTRL_RESET;
      rd_sel_r   <= '0;
      rd_empty_r <= 1'b1;
      rd_hold_r  <= '0;
    end
    else
    begin
      if (wr_ctrl)
        ctrl_r <= wdata_in[1:0];
      rd_sel_r   <= addr_in;
      rd_empty_r <= !(rd_result && res_q.out_valid);
      rd_hold_r  <= rd_in ? rd_mux : '0;
    end
  end

  // Popped word is already in the FIFO output register next cycle
  wire rd_was_result = (rd_sel_r == ADDR_RESULT) && !rd_empty_r;
  assign rdata_out = rd_was_result ? 32'(res_q.out_data) : rd_hold_r;

  // Assertions
  localparam int FULL_LAST  = 12;
  localparam int SHORT_LAST = 10;

  // Address field moves down in short mode
  wire [ADDR_BITS-1:0] addr_field = cfg_short_r
                       ? data_out[SHORT_BITS +: ADDR_BITS]
                       : data_out[RES_BITS +: ADDR_BITS];

  sequence s_start_full;
    start_ok && !ctrl_r[CTRL_SHORT_BIT] && RES_BITS == FULL_BITS;
  endsequence

  sequence s_walk_full;
    ##FULL_LAST (state_r == ST_CONVERT && idx_r == '0)
    ##1 (state_r == ST_LOAD);
  endsequence

  sequence s_start_short;
    start_ok && ctrl_r[CTRL_SHORT_BIT] && RES_BITS == FULL_BITS;
  endsequence

  sequence s_walk_short;
    ##SHORT_LAST (state_r == ST_CONVERT
                  && idx_r == IDX_W'(FULL_BITS - SHORT_BITS))
    ##1 (state_r == ST_LOAD);
  endsequence

  property p_start_src;
    @(posedge mclk_in) disable iff (reset_in)
    (state_r == ST_IDLE && state_nxt == ST_CONVERT)
      |-> (!cs_n_in && req_n_r && !convert_request_n_in);
  endproperty
  a_start_src: assert property (p_start_src)
    else $error("conversion began without a select and request");

  property p_clear;
    @(posedge mclk_in) disable iff (reset_in)
    start_ok |=> (bdr_r == '0 && state_r == ST_CONVERT);
  endproperty
  a_clear: assert property (p_clear)
    else $error("decision register not cleared at start");

  property p_no_restart;
    @(posedge mclk_in) disable iff (reset_in)
    (state_r == ST_CONVERT && !last_bit)
      |=> (state_r == ST_CONVERT && idx_r == $past(idx_r) - 1'b1);
  endproperty
  a_no_restart: assert property (p_no_restart)
    else $error("conversion restarted or skipped a bit");

  property p_walk;
    @(posedge mclk_in) disable iff (reset_in)
    s_start_full |-> s_walk_full;
  endproperty
  a_walk: assert property (p_walk)
    else $error("full conversion did not take twelve decisions");

  property p_walk_short;
    @(posedge mclk_in) disable iff (reset_in)
    s_start_short |-> s_walk_short;
  endproperty
  a_walk_short: assert property (p_walk_short)
    else $error("short conversion did not take ten decisions");

  property p_latch;
    @(posedge mclk_in) disable iff (reset_in)
    load_go |=> (data_out == $past(result_word)
                 && addr_field == $past(addr_word));
  endproperty
  a_latch: assert property (p_latch)
    else $error("output latch missed result or address");

  property p_single;
    @(posedge mclk_in) disable iff (reset_in)
    !cfg_pair_mode_sel_r |-> (neg_sel_out == SEL_COMMON
                     && pos_sel_out == {1'b0, cfg_addr_r});
  endproperty
  a_single: assert property (p_single)
    else $error("single-ended select wrong");

  property p_pair;
    @(posedge mclk_in) disable iff (reset_in)
    cfg_pair_mode_sel_r |-> (pos_sel_out[3:1] == neg_sel_out[3:1]
                    && pos_sel_out[0] == cfg_addr_r[0]
                    && neg_sel_out[0] == !cfg_addr_r[0]
                    && neg_sel_out != SEL_COMMON);
  endproperty
  a_pair: assert property (p_pair)
    else $error("differential pair select wrong");

  property p_hold_cfg;
    @(posedge mclk_in) disable iff (reset_in)
    busy_out |=> ($stable(cfg_addr_r) && $stable(cfg_pair_mode_sel_r)
                  && $stable(span_sel_out));
  endproperty
  a_hold_cfg: assert property (p_hold_cfg)
    else $error("configuration changed during conversion");

  property p_cfg_capture;
    @(posedge mclk_in) disable iff (reset_in)
    start_ok |=> (cfg_addr_r == $past({channel_addr_bit2_in,
                                       channel_addr_bit1_in,
                                       channel_addr_bit0_in})
                  && cfg_pair_mode_sel_r == $past(pair_mode_sel_in)
                  && span_sel_out == span_e'($past({polarity_select_in,
                                                    gain_select_in})));
  endproperty
  a_cfg_capture: assert property (p_cfg_capture)
    else $error("configuration not captured at start");

  property p_rd_idle;
    @(posedge mclk_in) disable iff (reset_in)
    !$past(rd_in) |-> (rdata_out == 32'h0);
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data shown without a read");

  property p_latch_stable;
    @(posedge mclk_in) disable iff (reset_in)
    (state_r == ST_CONVERT) |=> $stable(data_out);
  endproperty
  a_latch_stable: assert property (p_latch_stable)
    else $error("output latch changed mid conversion");

endmodule // sar_conversion_and_mux_select

// ### testbench/front_end_model.sv
/*
  Front-end model: analog input levels, multiplexer and comparator.
  Assumes select codes 0..7 for the inputs and SEL_COMMON for common.
*/
`timescale 1ns/100ps
module front_end_model
  import sar_pkg::*;
(
  input  wire logic [3:0]  pos_sel_in, // Positive mux select
  input  wire logic [3:0]  neg_sel_in, // Negative mux select
  input  wire logic [11:0] trial_in,   // DAC trial code
  output logic             cmp_out     // High: difference >= trial
);
  // Fixed levels per input keep the expected codes easy to derive
  function automatic logic [11:0] vin(input logic [3:0] s);
    return (s == SEL_COMMON) ? 12'h010 : {1'b0, s[2:0], 8'h23};
  endfunction

  // A negative difference decides every bit low
  assign cmp_out = (vin(pos_sel_in) >= vin(neg_sel_in)) &&
                   ((vin(pos_sel_in) - vin(neg_sel_in)) >= trial_in);
endmodule // front_end_model

// ### testbench/tb_top.sv
/*
  Self-checking bench for the converter control block.
  Assumes the front-end model answers within the trial cycle.
*/
`timescale 1ns/100ps
module tb_top;
  import sar_pkg::*;
  typedef struct packed
  {
    logic [5:0]  c;
    logic [3:0]  p;
    logic [3:0]  q;
    logic [11:0] r;
  } row_s;
  // Config {polarity, gain, pair, a2, a1, a0}, pos, neg, result
  row_s rows [6] = '{'{6'h00, 4'h0, 4'h8, 12'h013},
                     '{6'h17, 4'h7, 4'h8, 12'h713},
                     '{6'h25, 4'h5, 4'h8, 12'h513},
                     '{6'h3A, 4'h2, 4'h3, 12'h000},
                     '{6'h0D, 4'h5, 4'h4, 12'h100},
                     '{6'h09, 4'h1, 4'h0, 12'h100}};
  logic        mclk_in  = 1'b0;
  logic        reset_in = 1'b1;
  logic        cs_n     = 1'b1;
  logic        req_n    = 1'b1;
  logic [5:0]  cfg      = 6'h00;
  logic [3:0]  addr     = 4'h0;
  logic [31:0] wdata    = 32'h0;
  logic        wr       = 1'b0;
  logic        rd       = 1'b0;
  logic        cmp;
  logic [11:0] trial;
  logic        smp;
  logic        busy;
  logic [3:0]  pos;
  logic [3:0]  neg;
  span_e       span;
  logic [15:0] dout;
  logic [31:0] rdata;
  logic [31:0] rv;
  int          fail_count = 0;
  int          cmp_count  = 0;
  int          n;
  int          k;

  always #50 mclk_in = ~mclk_in;

  sar_conversion_and_mux_select i_sar_conversion_and_mux_select (
    .mclk_in(mclk_in), .reset_in(reset_in), .cs_n_in(cs_n),
    .convert_request_n_in(req_n), .pair_mode_sel_in(cfg[3]),
    .channel_addr_bit2_in(cfg[2]), .channel_addr_bit1_in(cfg[1]),
    .channel_addr_bit0_in(cfg[0]), .gain_select_in(cfg[4]),
    .polarity_select_in(cfg[5]), .comparator_in(cmp),
    .trial_code_out(trial), .sample_out(smp), .pos_sel_out(pos),
    .neg_sel_out(neg), .span_sel_out(span), .busy_out(busy),
    .data_out(dout), .addr_in(addr), .wdata_in(wdata), .wr_in(wr),
    .rd_in(rd), .rdata_out(rdata));

  front_end_model i_front_end_model (
    .pos_sel_in(pos), .neg_sel_in(neg), .trial_in(trial), .cmp_out(cmp));

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e)
    begin
      fail_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  task automatic report_and_stop();
    $display("Counts: %0d compares, %0d mismatches", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic go(input logic [5:0] c, input logic sel_n);
    @(posedge mclk_in);
    cfg   <= c;
    cs_n  <= sel_n;
    req_n <= 1'b0;
    @(posedge mclk_in);
    req_n <= 1'b1;
    cs_n  <= 1'b1;
  endtask

  // Length of the busy pulse in n, then the acquire gap
  task automatic finish_conv();
    n = 0;
    @(negedge mclk_in);
    if (busy !== 1'b1)
      @(negedge mclk_in);
    while (busy === 1'b1 && n < 60)
    begin
      n++;
      @(negedge mclk_in);
    end
    repeat (2) @(posedge mclk_in);
  endtask

  task automatic idle_chk();
    repeat (4) @(negedge mclk_in);
    chk(busy, 1'b0);
  endtask

  task automatic rreg(input logic [3:0] a);
    @(posedge mclk_in);
    addr <= a;
    rd   <= 1'b1;
    @(posedge mclk_in);
    rd <= 1'b0;
    #1 rv = rdata;
  endtask

  task automatic wreg(input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk_in);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge mclk_in);
    wr <= 1'b0;
  endtask

  initial
  begin
    #3_000_000;
    fail_count++;
    report_and_stop();
  end

  initial
  begin
    repeat (3) @(posedge mclk_in);
    reset_in <= 1'b0;
    #1;
    chk(busy, 1'b0);
    chk(smp, 1'b1);
    chk(dout, 16'h0000);
    chk(pos, 4'h0);
    chk(neg, SEL_COMMON);
    chk(span, 2'h0);
    rreg(ADDR_CTRL);
    chk(rv, 32'h1);
    $display("Test done: reset");
    foreach (rows[i])
    begin
      go(rows[i].c, 1'b0);
      #1;
      chk(pos, rows[i].p);
      chk(neg, rows[i].q);
      chk(span, rows[i].c[5:4]);
      finish_conv();
      chk(n, 13);
      chk(dout, {rows[i].c[3:0], rows[i].r});
      rreg(ADDR_RESULT);
      chk(rv, {16'h0, rows[i].c[3:0], rows[i].r});
    end
    $display("Test done: table");
    go(6'h17, 1'b0);
    go(6'h00, 1'b0);
    #1;
    chk(pos, 4'h7);
    chk(dout, 16'h9100);
    finish_conv();
    chk(dout, 16'h7713);
    rreg(ADDR_RESULT);
    chk(rv, 32'h7713);
    rreg(ADDR_STATUS);
    chk(rv[STAT_AVAIL_BIT], 1'b0);
    rreg(ADDR_LATCH);
    chk(rv, 32'h7713);
    $display("Test done: restart ignored");
    go(6'h00, 1'b1);
    idle_chk();
    wreg(ADDR_CTRL, 32'h0);
    go(6'h00, 1'b0);
    idle_chk();
    wreg(ADDR_CTRL, 32'h3);
    go(6'h17, 1'b0);
    finish_conv();
    chk(n, 11);
    chk(dout, {2'b00, 4'h7, 10'h1C4});
    rreg(ADDR_RESULT);
    chk(rv, {16'h0, 2'b00, 4'h7, 10'h1C4});
    wreg(ADDR_CTRL, 32'h1);
    rreg(4'h2);
    chk(rv, 32'h0);
    $display("Test done: refusals and short mode");
    repeat (8)
    begin
      go(6'h05, 1'b0);
      finish_conv();
    end
    rreg(ADDR_STATUS);
    chk(rv[STAT_FULL_BIT], 1'b1);
    go(6'h07, 1'b0);
    repeat (20) @(negedge mclk_in);
    chk(busy, 1'b1);
    chk(dout, 16'h5513);
    chk(smp, 1'b0);
    chk(trial, 12'h000);
    rreg(ADDR_STATUS);
    chk(rv[3:0], 4'h7);
    rreg(ADDR_RESULT);
    chk(rv, 32'h5513);
    finish_conv();
    chk(dout, 16'h7713);
    k = 0;
    rreg(ADDR_STATUS);
    while (rv[STAT_AVAIL_BIT] === 1'b1 && k < 12)
    begin
      rreg(ADDR_RESULT);
      k++;
      rreg(ADDR_STATUS);
    end
    chk(k, 8);
    rreg(ADDR_RESULT);
    chk(rv, 32'h0);
    $display("Test done: buffer fill and drain");
    go(6'h12, 1'b0);
    repeat (3) @(posedge mclk_in);
    reset_in <= 1'b1;
    #1;
    chk(busy, 1'b0);
    chk(smp, 1'b1);
    chk(dout, 16'h0000);
    chk(trial, 12'h000);
    chk(pos, 4'h0);
    chk(neg, SEL_COMMON);
    @(posedge mclk_in);
    reset_in <= 1'b0;
    rreg(ADDR_CTRL);
    chk(rv, 32'h1);
    go(6'h12, 1'b0);
    finish_conv();
    chk(n, 13);
    chk(dout, 16'h2213);
    $display("Test done: reset mid-run");
    report_and_stop();
  end
endmodule // tb_top
